// >>> exc_log_pkg.sv
// constants shared by the error and functional exception logger
package exc_log_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_ERR = 16;
  localparam int NUM_FUNC = 8;
  localparam int NUM_CLASS = 4;

  // register byte offsets
  localparam logic [7:0] OFF_ERR_STATUS = 8'h00;
  localparam logic [7:0] OFF_ERR_CLEAR = 8'h04;
  localparam logic [7:0] OFF_ERR_ENABLE = 8'h08;
  localparam logic [7:0] OFF_ERR_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFF_ERR_MC0_EN = 8'h10;
  localparam logic [7:0] OFF_ERR_MC1_EN = 8'h14;
  localparam logic [7:0] OFF_CPU_ADDR = 8'h18;
  localparam logic [7:0] OFF_CPU_ATTR = 8'h1c;
  localparam logic [7:0] OFF_PCI_ADDR = 8'h20;
  localparam logic [7:0] OFF_PCI_ATTR = 8'h24;
  localparam logic [7:0] OFF_SB_SYND = 8'h28;
  localparam logic [7:0] OFF_SB_ADDR = 8'h2c;
  localparam logic [7:0] OFF_MB_SYND = 8'h30;
  localparam logic [7:0] OFF_MB_ADDR = 8'h34;
  localparam logic [7:0] OFF_FUNC_STATUS = 8'h38;
  localparam logic [7:0] OFF_FUNC_CLEAR = 8'h3c;
  localparam logic [7:0] OFF_FUNC_ENABLE = 8'h40;
  localparam logic [7:0] OFF_FUNC_MASK = 8'h44;
  localparam logic [7:0] OFF_DOORBELL = 8'h48;

  // error status bit positions
  localparam int ERR_CPU_TIMEOUT = 0;
  localparam int ERR_CPU_APAR = 1;
  localparam int ERR_CPU_DPAR = 2;
  localparam int ERR_CPU_DT_TIMEOUT = 3;
  localparam int ERR_SB = 4;
  localparam int ERR_SB_COUNT = 5;
  localparam int ERR_MB_CPU = 6;
  localparam int ERR_MB_SCRUB = 7;
  localparam int ERR_PCI_MABORT = 8;
  localparam int ERR_PCI_TABORT = 9;
  localparam int ERR_PCI_APAR = 10;
  localparam int ERR_PCI_DPAR = 11;
  localparam int ERR_PCI_SERR = 12;
  localparam int ERR_PCI_PERR = 13;
  localparam int ERR_PCI_DT_TIMEOUT = 14;
  localparam int ERR_PCI_RETRY = 15;
  // overflow flags sit above the error bits in status and clear
  localparam int OVF_LSB = 16;

  // logging classes: cpu, single-bit, multi-bit, pci
  localparam int CLS_CPU = 0;
  localparam int CLS_SB = 1;
  localparam int CLS_MB = 2;
  localparam int CLS_PCI = 3;
  localparam logic [15:0] CLASS_MASK [NUM_CLASS] =
    '{16'h000f, 16'h0030, 16'h00c0, 16'hff00};
  // pci errors that capture address and attributes (not serr/perr)
  localparam logic [15:0] PCI_CAPTURE_MASK = 16'hcf00;

  // functional status bit positions
  localparam int FN_DMA = 0;
  localparam int FN_DOORBELL = 1;
  localparam int FN_MSG0 = 2;
  localparam int FN_MSG1 = 3;
  localparam int FN_INBOUND_POST = 4;
  localparam int FN_UART0 = 5;
  localparam int FN_UART1 = 6;
  localparam int FN_ABORT = 7;
  localparam logic [7:0] FN_EDGE_MASK = 8'h8d;

  // values after reset
  localparam logic [15:0] ERR_ENABLE_RST = 16'h0000;
  localparam logic [15:0] ERR_ROUTE_RST = 16'h0000;
  localparam logic [7:0] FUNC_ENABLE_RST = 8'h00;
  localparam logic [7:0] FUNC_MASK_RST = 8'hff;

endpackage

// >>> error_exception_logger.sv
// error and functional exception logger with capture registers
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - cpu bus or delayed-transaction timeout sets status, captures cpu info
// - cpu address or data parity error sets status, captures cpu info
// - corrected single-bit error sets status, captures syndrome and address
// - single-bit counter overflow sets its own status, no new capture
// - multi-bit: scrub captures syndrome and address, cpu access address
// - pci master or target abort sets status, captures pci info
// - pci address or data parity error sets status, captures pci info
// - serr or perr sets own status, captures nothing
// - pci delayed-transaction timeout sets status, captures pci info
// - pci retry limit exceeded sets status, captures pci info
// - dma completion sets functional status, cleared by functional clear
// - any doorbell bit set raises doorbell status, doorbell reg clears
// - message 0 or 1 write sets its own status, functional clear clears
// - inbound post status is a level: head differs from tail
// - each uart status follows its pending interrupt level
// - abort switch press sets abort status, functional clear clears
// - cpu error logs only when enabled and no cpu status set
// - further cpu error sets cpu overflow, capture frozen until both clear
// - pci class logs like cpu class with its own overflow and freeze
// - single-bit error while one pending sets overflow, suspends logging
// - multi-bit error while one pending sets overflow, suspends logging
// - captured info holds until the logged status is cleared
// - errors ored onto one interrupt, functional onto another
// - per-error interrupt and two machine-check enables
// - disabled status reads zero; write one clears a set status
// - functional interrupt only for set status with mask clear
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
module error_exception_logger #(
  parameter int ADDR_WIDTH = 32,
  parameter int ATTR_WIDTH = 32,
  parameter int SYND_WIDTH = 8,
  parameter int DOORBELL_WIDTH = 16,
  parameter int POST_PTR_WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [exc_log_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [11:0] i_err_src,
  input wire logic i_pci_dt_timeout,
  input wire logic i_pci_retry_limit_err,
  input wire logic i_serr_n,
  input wire logic i_perr_n,
  input wire logic [ADDR_WIDTH-1:0] i_cpu_addr,
  input wire logic [ATTR_WIDTH-1:0] i_cpu_attr,
  input wire logic [ADDR_WIDTH-1:0] i_pci_addr,
  input wire logic [ATTR_WIDTH-1:0] i_pci_attr,
  input wire logic [SYND_WIDTH-1:0] i_sb_syndrome,
  input wire logic [ADDR_WIDTH-1:0] i_sb_addr,
  input wire logic [SYND_WIDTH-1:0] i_mb_syndrome,
  input wire logic [ADDR_WIDTH-1:0] i_mb_addr,
  input wire logic i_dma_done,
  input wire logic [DOORBELL_WIDTH-1:0] i_doorbell_set,
  input wire logic i_msg0_write,
  input wire logic i_msg1_write,
  input wire logic [POST_PTR_WIDTH-1:0] i_inbound_post_head,
  input wire logic [POST_PTR_WIDTH-1:0] i_inbound_post_tail,
  input wire logic [1:0] i_uart_irq,
  input wire logic i_abort_switch_in_n,
  output logic o_err_irq,
  output logic o_func_irq,
  output logic o_mcheck0,
  output logic o_mcheck1
);

  localparam int NE = exc_log_pkg::NUM_ERR;
  localparam int NF = exc_log_pkg::NUM_FUNC;
  localparam int NC = exc_log_pkg::NUM_CLASS;

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic [NE-1:0] src_prev;
  logic [NE-1:0] src_now;
  logic [NE-1:0] err_evt;
  logic [NE-1:0] err_status;
  logic [NE-1:0] err_enable;
  logic [NE-1:0] err_irq_en;
  logic [NE-1:0] err_mc0_en;
  logic [NE-1:0] err_mc1_en;
  logic [NE-1:0] err_visible;
  logic [NE-1:0] next_log;
  logic [NC-1:0] ovf;
  logic [NC-1:0] ovf_set;
  logic [ADDR_WIDTH-1:0] cpu_err_address_capture;
  logic [ATTR_WIDTH-1:0] cpu_err_attribute_capture;
  logic [ADDR_WIDTH-1:0] pci_err_address_capture;
  logic [ATTR_WIDTH-1:0] pci_err_attribute_capture;
  logic [SYND_WIDTH-1:0] single_bit_syndrome_capture;
  logic [ADDR_WIDTH-1:0] single_bit_address_capture;
  logic [SYND_WIDTH-1:0] multi_bit_syndrome_capture;
  logic [ADDR_WIDTH-1:0] multi_bit_address_capture;
  logic [NF-1:0] func_sticky;
  logic [NF-1:0] func_enable;
  logic [NF-1:0] func_mask;
  logic [NF-1:0] func_raw;
  logic [NF-1:0] func_visible;
  logic [NF-1:0] fsrc_prev;
  logic [NF-1:0] fsrc_now;
  logic [NF-1:0] func_evt;
  logic [DOORBELL_WIDTH-1:0] doorbell_reg;
  logic wr_err_clear;
  logic wr_func_clear;
  logic wr_doorbell;
  logic [NE-1:0] err_clr;
  logic [NC-1:0] ovf_clr;
  logic [NF-1:0] func_clr;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage feeds edge detection
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_prev <= 3'h7;
    end else begin
      pin_meta <= {i_abort_switch_in_n, i_perr_n, i_serr_n};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error sources: edges of detector levels
  assign src_now = {i_pci_retry_limit_err, i_pci_dt_timeout,
                    ~pin_sync[1], ~pin_sync[0], i_err_src};
  assign err_evt = src_now & ~src_prev & err_enable;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      src_prev <= '0;
    end else begin
      src_prev <= src_now;
    end
  end

  assign wr_err_clear = i_wr && (i_addr == exc_log_pkg::OFF_ERR_CLEAR);
  assign wr_func_clear = i_wr && (i_addr == exc_log_pkg::OFF_FUNC_CLEAR);
  assign wr_doorbell = i_wr && (i_addr == exc_log_pkg::OFF_DOORBELL);
  assign err_clr = wr_err_clear ? i_wdata[NE-1:0] : '0;
  assign ovf_clr = wr_err_clear ?
                   i_wdata[exc_log_pkg::OVF_LSB +: NC] : '0;
  assign func_clr = wr_func_clear ? i_wdata[NF-1:0] : '0;

  // a class logs only while it has no status and no overflow pending
  always_comb begin
    next_log = '0;
    ovf_set = '0;
    for (int c = 0; c < NC; c++) begin
      if ((|(err_status & exc_log_pkg::CLASS_MASK[c])) || ovf[c]) begin
        ovf_set[c] = |(err_evt & exc_log_pkg::CLASS_MASK[c]);
      end else begin
        next_log = next_log | (err_evt & exc_log_pkg::CLASS_MASK[c]);
      end
    end
  end

  // hardware set wins over a clear written in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      err_status <= '0;
      ovf <= '0;
    end else begin
      err_status <= (err_status & ~err_clr) | next_log;
      ovf <= (ovf & ~ovf_clr) | ovf_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture registers load only when a new first error is logged
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cpu_err_address_capture <= '0;
      cpu_err_attribute_capture <= '0;
    end else if (|(next_log & exc_log_pkg::CLASS_MASK[exc_log_pkg::CLS_CPU])) begin
      cpu_err_address_capture <= i_cpu_addr;
      cpu_err_attribute_capture <= i_cpu_attr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pci_err_address_capture <= '0;
      pci_err_attribute_capture <= '0;
    end else if (|(next_log & exc_log_pkg::PCI_CAPTURE_MASK)) begin
      // serr and perr are outside this mask and leave the capture stale
      pci_err_address_capture <= i_pci_addr;
      pci_err_attribute_capture <= i_pci_attr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      single_bit_syndrome_capture <= '0;
      single_bit_address_capture <= '0;
    end else if (next_log[exc_log_pkg::ERR_SB]) begin
      // a count overflow alone reports through the held syndrome
      single_bit_syndrome_capture <= i_sb_syndrome;
      single_bit_address_capture <= i_sb_addr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      multi_bit_syndrome_capture <= '0;
      multi_bit_address_capture <= '0;
    end else begin
      if (|(next_log & exc_log_pkg::CLASS_MASK[exc_log_pkg::CLS_MB])) begin
        multi_bit_address_capture <= i_mb_addr;
      end
      if (next_log[exc_log_pkg::ERR_MB_SCRUB]) begin
        multi_bit_syndrome_capture <= i_mb_syndrome;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // functional exceptions
  assign fsrc_now = {~pin_sync[2], 1'b0, 1'b0, 1'b0, i_msg1_write,
                     i_msg0_write, |i_doorbell_set, i_dma_done};
  assign func_evt = fsrc_now & ~fsrc_prev & func_enable &
                    exc_log_pkg::FN_EDGE_MASK;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fsrc_prev <= '0;
    end else begin
      // one-cycle history, so a press gives exactly one event
      fsrc_prev <= fsrc_now;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      func_sticky <= '0;
    end else begin
      func_sticky <= (func_sticky & ~(func_clr & exc_log_pkg::FN_EDGE_MASK))
                     | func_evt;
    end
  end

  // doorbell bits: hardware set wins; software writes ones to clear them
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      doorbell_reg <= '0;
    end else if (wr_doorbell) begin
      doorbell_reg <= (doorbell_reg & ~i_wdata[DOORBELL_WIDTH-1:0])
                      | i_doorbell_set;
    end else begin
      doorbell_reg <= doorbell_reg | i_doorbell_set;
    end
  end

  always_comb begin
    func_raw = func_sticky;
    func_raw[exc_log_pkg::FN_DOORBELL] = |doorbell_reg;
    func_raw[exc_log_pkg::FN_INBOUND_POST] =
      (i_inbound_post_head != i_inbound_post_tail);
    func_raw[exc_log_pkg::FN_UART0] = i_uart_irq[0];
    func_raw[exc_log_pkg::FN_UART1] = i_uart_irq[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: disabled exceptions read zero and raise nothing
  assign err_visible = err_status & err_enable;
  assign func_visible = func_raw & func_enable;
  assign o_err_irq = |(err_visible & err_irq_en);
  assign o_mcheck0 = |(err_visible & err_mc0_en);
  assign o_mcheck1 = |(err_visible & err_mc1_en);
  assign o_func_irq = |(func_visible & ~func_mask);

  ////////////////////////////////////////////////////////////////////////////
  // register write port
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      err_enable <= exc_log_pkg::ERR_ENABLE_RST;
      err_irq_en <= exc_log_pkg::ERR_ROUTE_RST;
      err_mc0_en <= exc_log_pkg::ERR_ROUTE_RST;
      err_mc1_en <= exc_log_pkg::ERR_ROUTE_RST;
      func_enable <= exc_log_pkg::FUNC_ENABLE_RST;
      func_mask <= exc_log_pkg::FUNC_MASK_RST;
    end else if (i_wr) begin
      case (i_addr)
        exc_log_pkg::OFF_ERR_ENABLE: err_enable <= i_wdata[NE-1:0];
        exc_log_pkg::OFF_ERR_IRQ_EN: err_irq_en <= i_wdata[NE-1:0];
        exc_log_pkg::OFF_ERR_MC0_EN: err_mc0_en <= i_wdata[NE-1:0];
        exc_log_pkg::OFF_ERR_MC1_EN: err_mc1_en <= i_wdata[NE-1:0];
        exc_log_pkg::OFF_FUNC_ENABLE: func_enable <= i_wdata[NF-1:0];
        exc_log_pkg::OFF_FUNC_MASK: func_mask <= i_wdata[NF-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe; unmapped reads 0
  always_comb begin
    next_rdata = '0;
    case (i_addr)
      exc_log_pkg::OFF_ERR_STATUS:
        next_rdata = {{(32-exc_log_pkg::OVF_LSB-NC){1'b0}}, ovf, err_visible};
      exc_log_pkg::OFF_ERR_ENABLE: next_rdata[NE-1:0] = err_enable;
      exc_log_pkg::OFF_ERR_IRQ_EN: next_rdata[NE-1:0] = err_irq_en;
      exc_log_pkg::OFF_ERR_MC0_EN: next_rdata[NE-1:0] = err_mc0_en;
      exc_log_pkg::OFF_ERR_MC1_EN: next_rdata[NE-1:0] = err_mc1_en;
      exc_log_pkg::OFF_CPU_ADDR:
        next_rdata[ADDR_WIDTH-1:0] = cpu_err_address_capture;
      exc_log_pkg::OFF_CPU_ATTR:
        next_rdata[ATTR_WIDTH-1:0] = cpu_err_attribute_capture;
      exc_log_pkg::OFF_PCI_ADDR:
        next_rdata[ADDR_WIDTH-1:0] = pci_err_address_capture;
      exc_log_pkg::OFF_PCI_ATTR:
        next_rdata[ATTR_WIDTH-1:0] = pci_err_attribute_capture;
      exc_log_pkg::OFF_SB_SYND:
        next_rdata[SYND_WIDTH-1:0] = single_bit_syndrome_capture;
      exc_log_pkg::OFF_SB_ADDR:
        next_rdata[ADDR_WIDTH-1:0] = single_bit_address_capture;
      exc_log_pkg::OFF_MB_SYND:
        next_rdata[SYND_WIDTH-1:0] = multi_bit_syndrome_capture;
      exc_log_pkg::OFF_MB_ADDR:
        next_rdata[ADDR_WIDTH-1:0] = multi_bit_address_capture;
      exc_log_pkg::OFF_FUNC_STATUS: next_rdata[NF-1:0] = func_visible;
      exc_log_pkg::OFF_FUNC_ENABLE: next_rdata[NF-1:0] = func_enable;
      exc_log_pkg::OFF_FUNC_MASK: next_rdata[NF-1:0] = func_mask;
      exc_log_pkg::OFF_DOORBELL:
        next_rdata[DOORBELL_WIDTH-1:0] = doorbell_reg;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_cpu_first_log: assert property (@(posedge i_clk) disable iff (i_srst)
    (err_evt[0] && !(|err_status[3:0]) && !ovf[0])
    |=> err_status[0] && cpu_err_address_capture == $past(i_cpu_addr))
    else $error("cpu timeout not logged with its address");

  chk_cpu_overflow_set: assert property (@(posedge i_clk) disable iff (i_srst)
    ((|err_evt[3:0]) && (|err_status[3:0])) |=> ovf[0])
    else $error("cpu overflow flag not set");

  chk_cpu_capture_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    ((|err_status[3:0]) && !wr_err_clear)[*2]
    |-> $stable(cpu_err_address_capture))
    else $error("cpu capture changed while an error is held");

  chk_sb_capture: assert property (@(posedge i_clk) disable iff (i_srst)
    (err_evt[4] && !(|err_status[5:4]) && !ovf[1])
    |=> single_bit_syndrome_capture == $past(i_sb_syndrome))
    else $error("single-bit syndrome not captured");

  chk_mb_proc_syndrome: assert property (@(posedge i_clk) disable iff (i_srst)
    (next_log[6] && !next_log[7]) |=> $stable(multi_bit_syndrome_capture))
    else $error("cpu multi-bit error changed the syndrome");

  chk_pci_serr_nocap: assert property (@(posedge i_clk) disable iff (i_srst)
    (next_log[12] && !(|(next_log & 16'hcf00)))
    |=> $stable(pci_err_address_capture))
    else $error("serr altered the pci capture");

  chk_mb_overflow_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (ovf[2] && !ovf_clr[2]) |=> ovf[2] && !(|next_log[7:6]) [*1])
    else $error("multi-bit overflow lost without a clear");

  chk_status_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    (err_clr[9] && !next_log[9]) |=> !err_status[9])
    else $error("write one did not clear status");

  chk_post_level: assert property (@(posedge i_clk) disable iff (i_srst)
    func_enable[4] |-> func_visible[4] ==
      (i_inbound_post_head != i_inbound_post_tail))
    else $error("inbound post status does not follow pointers");

  chk_abort_edge: assert property (@(posedge i_clk) disable iff (i_srst)
    (pin_prev[2] && !pin_sync[2] && func_enable[7]) |=> func_sticky[7])
    else $error("abort press not recorded");

  chk_func_irq_mask: assert property (@(posedge i_clk) disable iff (i_srst)
    (&func_mask) |-> !o_func_irq)
    else $error("functional interrupt while all masked");

endmodule

// >>> irq_sink_model.sv
// far-side model: interrupt controller channels and machine-check inputs
module irq_sink_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_err_irq,
  input wire logic i_func_irq,
  input wire logic i_mcheck0,
  input wire logic i_mcheck1,
  output logic [3:0] o_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // level inputs latched as pending, the way a controller holds a request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_seen <= 4'h0;
    end else begin
      o_seen <= o_seen | {i_mcheck1, i_mcheck0, i_func_irq, i_err_irq};
    end
  end
endmodule

// >>> error_exception_logger_tb.sv
// self-checking bench for the error and functional exception logger
module error_exception_logger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0;
  logic [31:0] rdata;
  logic [11:0] esrc = 12'h000;
  logic pdt = 1'b0, prl = 1'b0, serr_n = 1'b1, perr_n = 1'b1;
  logic [31:0] caddr = 32'h0, cattr = 32'h0, paddr = 32'h0, pattr = 32'h0;
  logic [31:0] sbaddr = 32'h0, mbaddr = 32'h0;
  logic [7:0] sbsyn = 8'h00, mbsyn = 8'h00;
  logic dma = 1'b0, m0 = 1'b0, m1 = 1'b0, abt_n = 1'b1;
  logic [15:0] db = 16'h0, ph = 16'h0, pt = 16'h0;
  logic [1:0] uart = 2'b00;
  logic eirq, firq, mc0, mc1;
  logic [3:0] seen;
  logic [31:0] seed = 32'h0e36;
  logic [31:0] ecap [8];
  logic [7:0] cv = 8'h00;
  int miscompares = 0;
  int cmp_count = 0;

  error_exception_logger dut (
    .i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_err_src(esrc),
    .i_pci_dt_timeout(pdt), .i_pci_retry_limit_err(prl),
    .i_serr_n(serr_n), .i_perr_n(perr_n), .i_cpu_addr(caddr),
    .i_cpu_attr(cattr), .i_pci_addr(paddr), .i_pci_attr(pattr),
    .i_sb_syndrome(sbsyn), .i_sb_addr(sbaddr), .i_mb_syndrome(mbsyn),
    .i_mb_addr(mbaddr), .i_dma_done(dma), .i_doorbell_set(db),
    .i_msg0_write(m0), .i_msg1_write(m1), .i_inbound_post_head(ph),
    .i_inbound_post_tail(pt), .i_uart_irq(uart),
    .i_abort_switch_in_n(abt_n), .o_err_irq(eirq), .o_func_irq(firq),
    .o_mcheck0(mc0), .o_mcheck1(mc1)
  );
  irq_sink_model far_end (
    .i_clk(clk), .i_srst(srst), .i_err_irq(eirq), .i_func_irq(firq),
    .i_mcheck0(mc0), .i_mcheck1(mc1), .o_seen(seen)
  );

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] bitv(input int n);
    return 32'h1 << n;
  endfunction
  // overflow flag of the class holding error bit n
  function automatic logic [31:0] ovf(input int n);
    return (n < 4) ? bitv(16) : (n < 6) ? bitv(17) : (n < 8) ? bitv(18)
      : bitv(19);
  endfunction
  // expected capture registers, 0x18 upwards in steps of four
  function automatic void upd(input int n, input logic [31:0] v);
    if (n < 4) begin
      ecap[0] = v;
      ecap[1] = ~v;
      cv[1:0] = 2'b11;
    end else if (n == 4) begin
      ecap[4] = {24'h0, v[7:0]};
      ecap[5] = v;
      cv[5:4] = 2'b11;
    end else if (n == 6 || n == 7) begin
      ecap[7] = ~v;
      cv[7] = 1'b1;
      if (n == 7) begin
        ecap[6] = {24'h0, v[15:8]};
        cv[6] = 1'b1;
      end
    end else if (n >= 8 && n != 12 && n != 13) begin
      ecap[2] = v ^ 32'h5a5a5a5a;
      ecap[3] = v + 32'h1;
      cv[3:2] = 2'b11;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task summarize();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // settle time after the edge lets combinational outputs follow
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task setcap(input logic [31:0] v);
    @(posedge clk);
    caddr <= v;
    cattr <= ~v;
    paddr <= v ^ 32'h5a5a5a5a;
    pattr <= v + 32'h1;
    sbaddr <= v;
    mbaddr <= ~v;
    sbsyn <= v[7:0];
    mbsyn <= v[15:8];
  endtask
  // error bits 0..15, functional edge sources at 16 plus their bit
  task ev(input int n);
    @(posedge clk);
    case (n)
      12: serr_n <= 1'b0;
      13: perr_n <= 1'b0;
      14: pdt <= 1'b1;
      15: prl <= 1'b1;
      16: dma <= 1'b1;
      18: m0 <= 1'b1;
      19: m1 <= 1'b1;
      23: abt_n <= 1'b0;
      default: esrc[n] <= 1'b1;
    endcase
    repeat (4) @(posedge clk);
    esrc <= 12'h000;
    {pdt, prl, dma, m0, m1} <= 5'h00;
    {serr_n, perr_n, abt_n} <= 3'b111;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [15:0] dbv;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rchk(exc_log_pkg::OFF_ERR_ENABLE, 32'h0);
    rchk(exc_log_pkg::OFF_FUNC_MASK, 32'hff);
    rchk(8'h4c, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wreg(exc_log_pkg::OFF_ERR_ENABLE + 8'(4 * k), 32'hffff);
    end
    for (int n = 0; n < 16; n++) begin
      v = rnd();
      setcap(v);
      ev(n);
      upd(n, v);
      rchk(exc_log_pkg::OFF_ERR_STATUS, bitv(n));
      chk({29'h0, eirq, mc0, mc1}, 32'h7);
      setcap(rnd());
      ev(n ^ 1);
      rchk(exc_log_pkg::OFF_ERR_STATUS, bitv(n) | ovf(n));
      for (int k = 0; k < 8; k++) begin
        if (cv[k]) rchk(exc_log_pkg::OFF_CPU_ADDR + 8'(4 * k), ecap[k]);
      end
      wreg(exc_log_pkg::OFF_ERR_CLEAR, bitv(n));
      ev(n);
      rchk(exc_log_pkg::OFF_ERR_STATUS, ovf(n));
      wreg(exc_log_pkg::OFF_ERR_CLEAR, ovf(n));
      rchk(exc_log_pkg::OFF_ERR_STATUS, 32'h0);
      chk({29'h0, eirq, mc0, mc1}, 32'h0);
    end
    ev(2);
    wreg(exc_log_pkg::OFF_ERR_MC0_EN, 32'hfffb);
    chk({29'h0, eirq, mc0, mc1}, 32'h5);
    wreg(exc_log_pkg::OFF_ERR_ENABLE, 32'hfffb);
    rchk(exc_log_pkg::OFF_ERR_STATUS, 32'h0);
    chk({29'h0, eirq, mc0, mc1}, 32'h0);
    wreg(exc_log_pkg::OFF_ERR_ENABLE, 32'hffff);
    wreg(exc_log_pkg::OFF_ERR_CLEAR, bitv(2));
    wreg(exc_log_pkg::OFF_FUNC_ENABLE, 32'hff);
    wreg(exc_log_pkg::OFF_FUNC_MASK, 32'h0);
    for (int f = 0; f < 8; f++) begin
      if (exc_log_pkg::FN_EDGE_MASK[f]) begin
        ev(16 + f);
        rchk(exc_log_pkg::OFF_FUNC_STATUS, bitv(f));
        chk({31'h0, firq}, 32'h1);
        wreg(exc_log_pkg::OFF_FUNC_CLEAR, bitv(f));
        rchk(exc_log_pkg::OFF_FUNC_STATUS, 32'h0);
      end
    end
    dbv = 16'(rnd()) | 16'h0001;
    @(posedge clk);
    db <= dbv;
    @(posedge clk);
    db <= 16'h0;
    rchk(exc_log_pkg::OFF_DOORBELL, {16'h0, dbv});
    rchk(exc_log_pkg::OFF_FUNC_STATUS, bitv(1));
    wreg(exc_log_pkg::OFF_DOORBELL, {16'h0, dbv});
    rchk(exc_log_pkg::OFF_FUNC_STATUS, 32'h0);
    @(posedge clk);
    ph <= 16'hffff;
    uart <= 2'b11;
    rchk(exc_log_pkg::OFF_FUNC_STATUS, 32'h70);
    wreg(exc_log_pkg::OFF_FUNC_MASK, 32'h70);
    chk({31'h0, firq}, 32'h0);
    @(posedge clk);
    ph <= 16'h0000;
    uart <= 2'b01;
    rchk(exc_log_pkg::OFF_FUNC_STATUS, 32'h20);
    chk({28'h0, seen}, 32'hf);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
